// File: src/slpg_pkg.sv
// Purpose: Shared constants and types for the status LED pattern generator.
// Assumes: 50 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes: All phase durations are in milliseconds of the 1 ms tick.
package slpg_pkg;
  // Clock and time base.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_W = 16;

  // Register byte addresses.
  localparam logic [3:0] SYS_CTRL_OFS = 4'h0;
  localparam logic [3:0] FB_CTRL_OFS = 4'h4;
  localparam logic [3:0] LED_STAT_OFS = 4'h8;
  localparam int ADDR_W = 4;

  // System control bits.
  localparam int SYS_RUN_BIT = 0;
  localparam int SYS_FORMAT_BIT = 1;
  localparam int SYS_ERROR_BIT = 2;
  localparam int SYS_CRASH_BIT = 3;
  localparam int SYS_UPD_IDLE_BIT = 4;
  localparam int SYS_UPD_INST_BIT = 5;
  localparam int SYS_RESET_BIT = 6;

  // Fieldbus control bits; network state sits in bits 1:0.
  localparam int FB_NMT_LSB = 0;
  localparam int FB_AUTOBAUD_BIT = 2;
  localparam int FB_WARN_BIT = 3;
  localparam int FB_ERR_CTRL_BIT = 4;
  localparam int FB_BUS_OFF_BIT = 5;
  localparam int FB_RESET_BIT = 6;
  localparam logic [1:0] NMT_NONE = 2'h0;
  localparam logic [1:0] NMT_PREOP = 2'h1;
  localparam logic [1:0] NMT_OPER = 2'h2;
  localparam logic [1:0] NMT_STOPPED = 2'h3;

  localparam logic [7:0] SYS_CTRL_RST = 8'h00;
  localparam logic [7:0] FB_CTRL_RST = 8'h00;

  // Phase durations in ms.
  localparam int DUR_W = 11;
  localparam logic [DUR_W-1:0] MS_STEADY = 11'h001;
  localparam logic [DUR_W-1:0] MS_500 = 11'h1f4;
  localparam logic [DUR_W-1:0] MS_125 = 11'h07d;
  localparam logic [DUR_W-1:0] MS_200 = 11'h0c8;
  localparam logic [DUR_W-1:0] MS_1000 = 11'h3e8;
  localparam logic [DUR_W-1:0] MS_50 = 11'h032;

  // Colour bit 1 is yellow (system) or red (fieldbus); bit 0 is green.
  localparam logic [1:0] COL_OFF = 2'h0;
  localparam logic [1:0] COL_GRN = 2'h1;
  localparam logic [1:0] COL_ALT = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int STEP_W = 4;

  typedef enum logic [3:0] {
    PAT_OFF, PAT_STEADY_GRN, PAT_STEADY_ALT, PAT_BLINK_GRN, PAT_CRASH, PAT_UPD_IDLE,
    PAT_UPD_INST, PAT_PREOP, PAT_STOPPED, PAT_FLICKER, PAT_SINGLE_ALT, PAT_DOUBLE_ALT
  } slpg_pat_e;
endpackage : slpg_pkg

// File: src/slpg_top.sv
// Purpose: Drives the system and fieldbus bicolour indicators from software-set conditions.
// Assumes: Single clock, AXI4-Lite slave, one transfer of each direction at a time.
// Notes: Software writes the condition bits; the block chooses and times the pattern.
//
// How it works
// - Firmware running shows steady green on the system indicator.
// - File system formatting blinks the system indicator green.
// - A system error shows steady yellow on the system indicator.
// - A crash repeats three yellow then three green pulses of 500 ms on and 500 ms off.
// - Update idle alternates yellow and green for 500 ms each.
// - Update installing alternates yellow and green for 125 ms each.
// - A firmware reset leaves the system indicator dark.
// - The operational network state shows steady green on the fieldbus indicator.
// - The preoperational state blinks green 200 ms on and 200 ms off.
// - The stopped state gives one 200 ms green flash and 1000 ms off, repeating.
// - Auto baud detection flickers red and green with 50 ms phases.
// - A warning level gives one 200 ms red flash and 1000 ms off, repeating.
// - An error control event gives two 200 ms red flashes 200 ms apart, then 1000 ms off.
// - Bus off shows steady red on the fieldbus indicator.
// - Reset or no configuration leaves the fieldbus indicator dark.
`timescale 1ns/100ps
`default_nettype none

module slpg_top
  import slpg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic sys_clk, // System clock, 50 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic sys_led_green, // System indicator green.
  output logic sys_led_yellow, // System indicator yellow.
  output logic fb_led_green, // Fieldbus indicator green.
  output logic fb_led_red // Fieldbus indicator red.
);

  // Returns {last step, colour, duration} for a pattern step.
  function automatic logic [DUR_W+2:0] step_info(input slpg_pat_e pat,
                                                 input logic [STEP_W-1:0] step);
    logic last;
    logic [1:0] col;
    logic [DUR_W-1:0] dur;
    last = 1'b1;
    col = COL_OFF;
    dur = MS_STEADY;
    case (pat)
      PAT_STEADY_GRN: col = COL_GRN;
      PAT_STEADY_ALT: col = COL_ALT;
      PAT_BLINK_GRN, PAT_UPD_IDLE: begin
        col = step[0] ? ((pat == PAT_UPD_IDLE) ? COL_GRN : COL_OFF)
                      : ((pat == PAT_UPD_IDLE) ? COL_ALT : COL_GRN);
        dur = MS_500;
        last = step[0];
      end
      PAT_CRASH: begin
        col = step[0] ? COL_OFF : ((step < 4'h6) ? COL_ALT : COL_GRN);
        dur = MS_500;
        last = (step == 4'hb);
      end
      PAT_UPD_INST, PAT_FLICKER: begin
        col = step[0] ? COL_GRN : COL_ALT;
        dur = (pat == PAT_FLICKER) ? MS_50 : MS_125;
        last = step[0];
      end
      PAT_PREOP, PAT_STOPPED, PAT_SINGLE_ALT: begin
        col = step[0] ? COL_OFF : ((pat == PAT_SINGLE_ALT) ? COL_ALT : COL_GRN);
        dur = (step[0] && (pat != PAT_PREOP)) ? MS_1000 : MS_200;
        last = step[0];
      end
      PAT_DOUBLE_ALT: begin
        col = step[0] ? COL_OFF : COL_ALT;
        dur = (step == 4'h3) ? MS_1000 : MS_200;
        last = (step == 4'h3);
      end
      default: col = COL_OFF;
    endcase
    return {last, col, dur};
  endfunction

  // Register file and bus slave state.
  logic [7:0] sys_ctrl_ff, nxt_sys_ctrl;
  logic [7:0] fb_ctrl_ff, nxt_fb_ctrl;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // Time base and pattern engines.
  logic [TICK_W-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  slpg_pat_e want [2];
  slpg_pat_e sel_ff [2];
  slpg_pat_e nxt_sel [2];
  logic [STEP_W-1:0] step_ff [2];
  logic [STEP_W-1:0] nxt_step [2];
  logic [DUR_W-1:0] ms_ff [2];
  logic [DUR_W-1:0] nxt_ms [2];
  logic [1:0] col_ff [2];
  logic [1:0] nxt_col [2];

  always_comb begin
    nxt_sys_ctrl = sys_ctrl_ff;
    nxt_fb_ctrl = fb_ctrl_ff;
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (awready_ff && s_axi_awvalid) begin
      nxt_awready = 1'b0;
      nxt_awaddr = s_axi_awaddr;
    end
    if (wready_ff && s_axi_wvalid) begin
      nxt_wready = 1'b0;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    // Both halves held and no response pending: perform the write once.
    if (!awready_ff && !wready_ff && !bvalid_ff) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (awaddr_ff == SYS_CTRL_OFS) begin
        if (wstrb0_ff) begin
          nxt_sys_ctrl = {1'b0, wdata_ff[6:0]};
        end
      end else if (awaddr_ff == FB_CTRL_OFS) begin
        if (wstrb0_ff) begin
          nxt_fb_ctrl = {1'b0, wdata_ff[6:0]};
        end
      end else if (awaddr_ff != LED_STAT_OFS) begin
        nxt_bresp = RESP_SLVERR;
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    if (arready_ff && s_axi_arvalid) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      if (s_axi_araddr == SYS_CTRL_OFS) begin
        nxt_rdata = {24'h000000, sys_ctrl_ff};
      end else if (s_axi_araddr == FB_CTRL_OFS) begin
        nxt_rdata = {24'h000000, fb_ctrl_ff};
      end else if (s_axi_araddr == LED_STAT_OFS) begin
        nxt_rdata = {16'h0000, sel_ff[1], sel_ff[0], 4'h0, col_ff[1], col_ff[0]};
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = RESP_SLVERR;
      end
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_ctrl_ff <= SYS_CTRL_RST;
      fb_ctrl_ff <= FB_CTRL_RST;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      sys_ctrl_ff <= nxt_sys_ctrl;
      fb_ctrl_ff <= nxt_fb_ctrl;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  always_comb begin
    nxt_tick = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + 1'b1;
    if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
      nxt_tick_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // Condition selection. The system order is a fixed ranking, most severe first.
  always_comb begin
    want[0] = PAT_OFF;
    if (sys_ctrl_ff[SYS_RESET_BIT]) want[0] = PAT_OFF;
    else if (sys_ctrl_ff[SYS_CRASH_BIT]) want[0] = PAT_CRASH;
    else if (sys_ctrl_ff[SYS_ERROR_BIT]) want[0] = PAT_STEADY_ALT;
    else if (sys_ctrl_ff[SYS_UPD_INST_BIT]) want[0] = PAT_UPD_INST;
    else if (sys_ctrl_ff[SYS_UPD_IDLE_BIT]) want[0] = PAT_UPD_IDLE;
    else if (sys_ctrl_ff[SYS_FORMAT_BIT]) want[0] = PAT_BLINK_GRN;
    else if (sys_ctrl_ff[SYS_RUN_BIT]) want[0] = PAT_STEADY_GRN;
    want[1] = PAT_OFF;
    if (fb_ctrl_ff[FB_RESET_BIT]) want[1] = PAT_OFF;
    else if (fb_ctrl_ff[FB_BUS_OFF_BIT]) want[1] = PAT_STEADY_ALT;
    else if (fb_ctrl_ff[FB_ERR_CTRL_BIT]) want[1] = PAT_DOUBLE_ALT;
    else if (fb_ctrl_ff[FB_WARN_BIT]) want[1] = PAT_SINGLE_ALT;
    else if (fb_ctrl_ff[FB_AUTOBAUD_BIT]) want[1] = PAT_FLICKER;
    else if (fb_ctrl_ff[FB_NMT_LSB+1:FB_NMT_LSB] == NMT_OPER) want[1] = PAT_STEADY_GRN;
    else if (fb_ctrl_ff[FB_NMT_LSB+1:FB_NMT_LSB] == NMT_PREOP) want[1] = PAT_PREOP;
    else if (fb_ctrl_ff[FB_NMT_LSB+1:FB_NMT_LSB] == NMT_STOPPED) want[1] = PAT_STOPPED;
  end

  // Each indicator has its own copy of the same engine; only the pattern choice differs.
  for (genvar gi = 0; gi < 2; gi++) begin : g_eng
    always_comb begin
      logic [DUR_W+2:0] info;
      info = step_info(sel_ff[gi], step_ff[gi]);
      nxt_sel[gi] = sel_ff[gi];
      nxt_step[gi] = step_ff[gi];
      nxt_ms[gi] = ms_ff[gi];
      if (want[gi] != sel_ff[gi]) begin
        nxt_sel[gi] = want[gi];
        nxt_step[gi] = '0;
        nxt_ms[gi] = '0;
      end else if (tick_ff) begin
        if (ms_ff[gi] + 1'b1 >= info[DUR_W-1:0]) begin
          nxt_ms[gi] = '0;
          nxt_step[gi] = info[DUR_W+2] ? '0 : step_ff[gi] + 1'b1;
        end else begin
          nxt_ms[gi] = ms_ff[gi] + 1'b1;
        end
      end
      info = step_info(nxt_sel[gi], nxt_step[gi]);
      nxt_col[gi] = info[DUR_W+1:DUR_W];
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        sel_ff[gi] <= PAT_OFF;
        step_ff[gi] <= '0;
        ms_ff[gi] <= '0;
        col_ff[gi] <= COL_OFF;
      end else if (ce) begin
        sel_ff[gi] <= nxt_sel[gi];
        step_ff[gi] <= nxt_step[gi];
        ms_ff[gi] <= nxt_ms[gi];
        col_ff[gi] <= nxt_col[gi];
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign sys_led_green = col_ff[0][0];
  assign sys_led_yellow = col_ff[0][1];
  assign fb_led_green = col_ff[1][0];
  assign fb_led_red = col_ff[1][1];

endmodule // slpg_top

`default_nettype wire

// File: verif/slpg_led_watch.sv
// Purpose: Operator view of the two bicolour indicators.
// Assumes: Bit 1 is yellow or red, bit 0 is green.
// Notes: Both colours lit reads as 3 and so fails every compare.
`timescale 1ns/100ps
`default_nettype none
module slpg_led_watch (
  input wire logic sys_clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [1:0] sys_led, // System colours.
  input wire logic [1:0] fb_led, // Fieldbus colours.
  output logic [1:0] sys_col, // System colour seen.
  output logic [1:0] fb_col // Fieldbus colour seen.
);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_col <= 2'h0;
      fb_col <= 2'h0;
    end else begin
      sys_col <= sys_led;
      fb_col <= fb_led;
    end
  end
endmodule // slpg_led_watch
`default_nettype wire

// File: verif/slpg_monitor.sv
// Purpose: First-phase colour checks after condition writes; format, update installing, preoperational, stopped and warning are not checked.
// Assumes: Address and data of a write are taken together.
// Notes: Later phases are timed by the bench, not here.
`timescale 1ns/100ps
`default_nettype none
module slpg_monitor
  import slpg_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Address valid.
  input wire logic s_axi_awready, // Address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Strobes.
  input wire logic s_axi_wvalid, // Data valid.
  input wire logic s_axi_wready, // Data ready.
  input wire logic sys_led_green, // System green.
  input wire logic sys_led_yellow, // System yellow.
  input wire logic fb_led_green, // Fieldbus green.
  input wire logic fb_led_red // Fieldbus red.
);
  logic tk;
  logic ws;
  logic wf;
  logic [6:0] d;
  assign tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign ws = tk && (s_axi_awaddr == SYS_CTRL_OFS);
  assign wf = tk && (s_axi_awaddr == FB_CTRL_OFS);
  assign d = s_axi_wdata[6:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_SYS_RUN: assert property (
    ws && d == 7'h01 |-> ##3 (sys_led_green && !sys_led_yellow)[*3]) else $error("run not green");
  AST_SYS_ERR: assert property (
    ws && d[6:2] == 5'h01 |-> ##3 (sys_led_yellow && !sys_led_green)[*3]) else $error("no error");
  AST_SYS_CRASH: assert property (
    ws && d[6:3] == 4'h1 |-> ##3 sys_led_yellow && !sys_led_green) else $error("crash start");
  AST_SYS_IDLE: assert property (
    ws && d[6:2] == 5'h04 |-> ##3 (sys_led_yellow && !sys_led_green)[*3])
    else $error("idle not yellow first");
  AST_SYS_OFF: assert property (
    ws && d[6] |-> ##3 (!sys_led_green && !sys_led_yellow)[*3]) else $error("system lit");
  AST_SYS_ONE: assert property (
    !(sys_led_green && sys_led_yellow)) else $error("system both colours");
  AST_FB_OPER: assert property (
    wf && d == 7'h02 |-> ##3 fb_led_green && !fb_led_red) else $error("operational not green");
  AST_FB_FLICK: assert property (
    wf && d[6:2] == 5'h01 |-> ##3 fb_led_red ##1 $stable(fb_led_red)) else $error("flicker start");
  AST_FB_EVT: assert property (
    wf && d[6:4] == 3'h1 |-> ##3 fb_led_red && !fb_led_green) else $error("event not red");
  AST_FB_BOFF: assert property (
    wf && d[6:5] == 2'h1 |-> ##3 (fb_led_red && !fb_led_green)[*3]) else $error("bus off not red");
  AST_FB_OFF: assert property (
    wf && d[6] |-> ##3 (!fb_led_red && !fb_led_green)[*3]) else $error("fieldbus lit");
endmodule // slpg_monitor
bind slpg_top slpg_monitor u_mon (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .sys_led_green,
  .sys_led_yellow, .fb_led_green, .fb_led_red);
`default_nettype wire

// File: verif/tb_slpg_top.sv
// Purpose: Self-checking bench for the status LED pattern generator.
// Assumes: A tick of two clocks, so one ms is two cycles.
// Notes: Colours are sampled mid-phase, as the free tick may cut a first phase by one ms.
`timescale 1ns/100ps
`default_nettype none
module tb_slpg_top
  import slpg_pkg::*;
;
  localparam int TK = 2;
  localparam logic [7:0] DT [16] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h7f,
    8'h02, 8'h01, 8'h03, 8'h06, 8'h0e, 8'h1e, 8'h3e, 8'h7f, 8'h00};
  logic sys_clk, rst_b, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0] s_axi_bresp, s_axi_rresp, sc, fc;
  logic sys_led_green, sys_led_yellow, fb_led_green, fb_led_red;
  int fails = 0;
  int checks = 0;
  int ph[$];
  slpg_top #(.TICK_CYCLES(TK)) DUT (.sys_clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_led_green, .sys_led_yellow, .fb_led_green,
    .fb_led_red);
  slpg_led_watch u_watch (.sys_clk, .rst_b, .sys_led({sys_led_yellow, sys_led_green}),
    .fb_led({fb_led_red, fb_led_green}), .sys_col(sc), .fb_col(fc));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_up();
    fails++;
    finish_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Expected phases are colour times 10000 plus length in ms.
  task automatic play(input logic [3:0] a, input logic [7:0] d);
    int ms;
    wr(a, {24'h0, d}, 4'h1, RESP_OKAY);
    foreach (ph[i]) begin
      ms = ph[i] % 10000;
      repeat (ms * TK / 2) @(posedge sys_clk);
      chk("led", {30'h0, (a == FB_CTRL_OFS) ? fc : sc}, 32'(ph[i] / 10000));
      repeat (ms * TK / 2) @(posedge sys_clk);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    void'($urandom(32'h94a8));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(LED_STAT_OFS, 32'h0, RESP_OKAY);
    rd(4'hc, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'h1, 4'h1, RESP_SLVERR);
    r = $urandom;
    wr(FB_CTRL_OFS, r, 4'h1, RESP_OKAY);
    rd(FB_CTRL_OFS, {25'h0, r[6:0]}, RESP_OKAY);
    wr(FB_CTRL_OFS, ~r, 4'h0, RESP_OKAY);
    rd(FB_CTRL_OFS, {25'h0, r[6:0]}, RESP_OKAY);
    wr(LED_STAT_OFS, r, 4'h1, RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      case (k)
        0: ph = '{10300};
        1: ph = '{10500, 500, 10500};
        2: ph = '{20300};
        3: ph = '{20500, 500, 20500, 500, 20500, 500, 10500, 500, 10500, 500, 10500, 500};
        4: ph = '{20500, 10500, 20500};
        5: ph = '{20125, 10125, 20125, 10125};
        6: ph = '{300};
        7: ph = '{10300};
        8: ph = '{10200, 200, 10200};
        9: ph = '{10200, 1000, 10200};
        10: ph = '{20050, 10050, 20050, 10050};
        11: ph = '{20200, 1000, 20200};
        12: ph = '{20200, 200, 20200, 1000, 20200};
        13: ph = '{20300};
        default: ph = '{300};
      endcase
      play((k < 7) ? SYS_CTRL_OFS : FB_CTRL_OFS, DT[k]);
    end
    rd(LED_STAT_OFS, 32'h0, RESP_OKAY);
    // Clock enable low must freeze the slow alternation in its yellow phase.
    wr(SYS_CTRL_OFS, 32'h10, 4'h1, RESP_OKAY);
    r = {16'h0, 4'(PAT_OFF), 4'(PAT_UPD_IDLE), 4'h0, COL_OFF, COL_ALT};
    rd(LED_STAT_OFS, r, RESP_OKAY);
    ce <= 1'b0;
    repeat (1200 * TK / 2) @(posedge sys_clk);
    chk("frozen", {30'h0, sc}, {30'h0, COL_ALT});
    ce <= 1'b1;
    @(posedge sys_clk);
    // A reset in mid-run must clear the system conditions and darken both indicators.
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(SYS_CTRL_OFS, {24'h0, SYS_CTRL_RST}, RESP_OKAY);
    rd(LED_STAT_OFS, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule // tb_slpg_top
`default_nettype wire
